/* lpcg_pkg.sv */
// Constants and types shared by the peripheral clock gate block.
// Assumes a 32-bit APB slave on pclk, byte offsets within one page.
package lpcg_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATES_OFS = 12'h104;
  localparam logic [11:0] SLEEP_GATES_OFS = 12'h114;
  localparam logic [11:0] DEEP_GATES_OFS = 12'h124;
  localparam logic [11:0] STATUS_OFS = 12'h130;
  localparam logic [11:0] EFF_GATES_OFS = 12'h134;

  // ----------------------------------------
  // Gate field positions
  // ----------------------------------------
  localparam int ASYNC_SERIAL_BIT = 0;
  localparam int SYNC_SERIAL_BIT = 4;
  localparam int TWO_WIRE_PORT_BIT = 12;
  localparam int GP_COUNT_A_BIT = 16;
  localparam int GP_COUNT_B_BIT = 17;
  localparam int GP_COUNT_C_BIT = 18;
  localparam int COMPARATOR_A_BIT = 24;
  localparam int COMPARATOR_B_BIT = 25;
  localparam int COMPARATOR_C_BIT = 26;

  // Writable gate bits; all others are reserved
  localparam logic [31:0] GATE_MASK = 32'h0707_1011;
  // Every gate starts off
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Config and status fields
  // ----------------------------------------
  localparam int AUTO_GATE_BIT = 0;
  localparam logic AUTO_GATE_RESET = 1'b0;
  localparam int MODE_LSB = 0;
  localparam int FAULT_BIT = 8;

  // Power mode of the system
  typedef enum logic [1:0] {
    LPCG_RUN,
    LPCG_SLEEP,
    LPCG_DEEP
  } lpcg_mode_t;

endpackage

/* lpcg_gate_reg.sv */
// One gate register with run, sleep or deep-sleep role.
// Assumes the write strobe is a one-cycle pulse on pclk.
`timescale 1ns/1ns
`default_nettype none
module lpcg_gate_reg #(
  parameter logic [31:0] MASK = lpcg_pkg::GATE_MASK,
  parameter logic [31:0] RST = lpcg_pkg::GATE_RESET
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] value
);
  import lpcg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] bits; // Stored gates
  } lpcg_greg_t;
  lpcg_greg_t st_q;
  lpcg_greg_t st_d;

  // Next state: store only writable bits
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.bits = wdata & MASK;
    end
  end

  // State register, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{bits: RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.bits;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_gate_store;
    @(posedge pclk) disable iff (!presetn)
    wr_en |=> value == ($past(wdata) & MASK);
  endproperty
  a_gate_store: assert property (p_gate_store)
    else $error("gate register did not store written fields");

  property p_resv_zero;
    @(posedge pclk) disable iff (!presetn)
    (value & ~MASK) == 32'h0000_0000;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved gate bit is not zero");

endmodule
`default_nettype wire

/* lpcg_mode_sel.sv */
// Picks the gate register that rules the current power mode.
// Assumes mode and gate values come from flops on pclk.
`timescale 1ns/1ns
`default_nettype none
module lpcg_mode_sel (
  input wire logic pclk,
  input wire logic presetn,
  input wire lpcg_pkg::lpcg_mode_t mode,
  input wire logic auto_en,
  input wire logic [31:0] run_gates,
  input wire logic [31:0] sleep_gates,
  input wire logic [31:0] deep_gates,
  output logic [31:0] eff_gates
);
  import lpcg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] eff; // Enables driven to the units
  } lpcg_sel_t;
  lpcg_sel_t st_q;
  lpcg_sel_t st_d;

  // Select per mode; run register when auto gating is off
  always_comb begin
    st_d = st_q;
    if (!auto_en) begin
      st_d.eff = run_gates;
    end else begin
      case (mode)
        LPCG_SLEEP: begin
          st_d.eff = sleep_gates;
        end
        LPCG_DEEP: begin
          st_d.eff = deep_gates;
        end
        default: begin
          st_d.eff = run_gates;
        end
      endcase
    end
  end

  // Registered so the enables never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{eff: GATE_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign eff_gates = st_q.eff;

endmodule
`default_nettype wire

/* lpcg_top.sv */
// Clock gate control for the first peripheral group: run, sleep
// and deep-sleep gate registers, power mode tracking, registered
// unit clock enables and the unclocked-access fault check.
// Assumes an APB master on pclk, power requests and unit access
// strobes from logic on pclk, and gate cells outside that use
// unit_clk_en to stop each unit's clock.
//
// Operation
// - Set gate bit clocks its unit
// - Access to unclocked unit raises fault
// - All gate bits reset to zero
// - Separate run, sleep, deep-sleep gate registers
// - Sleep registers apply only with auto gating
// - Bits 18..16 gate timers two..zero
// - Bits 12, 4, 0 gate serial units
// - Bits 26..24 gate comparators two..zero
// - Reserved bits read zero, keep on update
// - Deep-sleep gate register at 0x124
// - Sleep gate register at 0x114
`timescale 1ns/1ns
`default_nettype none
module lpcg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic deep_req,
  input wire logic [31:0] unit_access,
  output logic [31:0] unit_clk_en,
  output logic unit_fault
);
  import lpcg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    lpcg_mode_t mode; // Current power mode
    logic auto_gate; // Auto gating select
    logic fault_seen; // Sticky fault flag
    logic [31:0] rdata; // Read data for the access phase
    logic rd_err; // Unmapped address seen in setup
    logic up; // High from first edge after reset
  } lpcg_top_st_t;
  lpcg_top_st_t st_q;
  lpcg_top_st_t st_d;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic setup; // Setup cycle of a transfer
  logic access; // Access phase, always completes
  logic wr_acc; // Write taking effect this edge
  logic hit_cfg; // Address hits run config
  logic hit_run; // Address hits run gates
  logic hit_sleep; // Address hits sleep gates
  logic hit_deep; // Address hits deep-sleep gates
  logic hit_stat; // Address hits status
  logic hit_eff; // Address hits effective gates
  logic mapped; // Address hits any register
  logic [31:0] rd_val; // Value read at this address
  logic [31:0] run_gates; // Run gate register
  logic [31:0] sleep_gates; // Sleep gate register
  logic [31:0] deep_gates; // Deep-sleep gate register
  logic [31:0] eff_gates; // Selected enables
  logic [31:0] status_val; // Status word

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && pwrite;

  // Address compare per register
  assign hit_cfg = paddr == RUN_CFG_OFS;
  assign hit_run = paddr == RUN_GATES_OFS;
  assign hit_sleep = paddr == SLEEP_GATES_OFS;
  assign hit_deep = paddr == DEEP_GATES_OFS;
  assign hit_stat = paddr == STATUS_OFS;
  assign hit_eff = paddr == EFF_GATES_OFS;
  assign mapped = hit_cfg || hit_run || hit_sleep || hit_deep || hit_stat || hit_eff;

  // Status word: mode code and sticky fault
  always_comb begin
    status_val = 32'h0000_0000;
    status_val[MODE_LSB +: 2] = st_q.mode;
    status_val[FAULT_BIT] = st_q.fault_seen;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_cfg) begin
      rd_val[AUTO_GATE_BIT] = st_q.auto_gate;
    end else if (hit_run) begin
      rd_val = run_gates;
    end else if (hit_sleep) begin
      rd_val = sleep_gates;
    end else if (hit_deep) begin
      rd_val = deep_gates;
    end else if (hit_stat) begin
      rd_val = status_val;
    end else if (hit_eff) begin
      rd_val = eff_gates;
    end
  end

  // ----------------------------------------
  // Gate registers
  // ----------------------------------------
  // Three copies with one layout, one per power mode
  lpcg_gate_reg u_run_gates (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && hit_run),
    .wdata(pwdata),
    .value(run_gates)
  );

  lpcg_gate_reg u_sleep_gates (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && hit_sleep),
    .wdata(pwdata),
    .value(sleep_gates)
  );

  lpcg_gate_reg u_deep_gates (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && hit_deep),
    .wdata(pwdata),
    .value(deep_gates)
  );

  // Effective enables for the current mode
  lpcg_mode_sel u_sel (
    .pclk(pclk),
    .presetn(presetn),
    .mode(st_q.mode),
    .auto_en(st_q.auto_gate),
    .run_gates(run_gates),
    .sleep_gates(sleep_gates),
    .deep_gates(deep_gates),
    .eff_gates(eff_gates)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.up = 1'b1;
    // Power mode tracker; deep sleep wins over sleep
    case (st_q.mode)
      LPCG_RUN: begin
        if (deep_req) begin
          st_d.mode = LPCG_DEEP;
        end else if (sleep_req) begin
          st_d.mode = LPCG_SLEEP;
        end
      end
      LPCG_SLEEP: begin
        if (deep_req) begin
          st_d.mode = LPCG_DEEP;
        end else if (!sleep_req) begin
          st_d.mode = LPCG_RUN;
        end
      end
      LPCG_DEEP: begin
        // Leaving deep sleep falls back to sleep if still asked
        if (!deep_req && sleep_req) begin
          st_d.mode = LPCG_SLEEP;
        end else if (!deep_req) begin
          st_d.mode = LPCG_RUN;
        end
      end
      default: begin
        st_d.mode = LPCG_RUN;
      end
    endcase
    // Auto gating select in run config
    if (wr_acc && hit_cfg) begin
      st_d.auto_gate = pwdata[AUTO_GATE_BIT];
    end
    // Fault flag: write one clears, new fault wins
    if (wr_acc && hit_stat && pwdata[FAULT_BIT]) begin
      st_d.fault_seen = 1'b0;
    end
    if (unit_fault) begin
      st_d.fault_seen = 1'b1;
    end
    // Read data and error caught in setup
    if (setup) begin
      st_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
      st_d.rd_err = !mapped;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{mode: LPCG_RUN, auto_gate: AUTO_GATE_RESET, fault_seen: 1'b0,
                rdata: 32'h0000_0000, rd_err: 1'b0, up: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // No wait states; error only for unmapped addresses
  assign pready = 1'b1;
  assign pslverr = access && st_q.rd_err;
  assign prdata = st_q.rdata;

  // Each set bit keeps its unit clocked
  assign unit_clk_en = eff_gates & GATE_MASK;

  // Access to a unit with its clock stopped
  assign unit_fault = |(unit_access & GATE_MASK & ~unit_clk_en);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rd_setup(logic [11:0] ofs);
    psel && !penable && !pwrite && paddr == ofs;
  endsequence

  sequence s_rd_access;
    psel && penable && !pwrite;
  endsequence

  // Setup cycle aimed at no register
  sequence s_bad_setup;
    psel && !penable && !mapped;
  endsequence

  // Access phase of either direction
  sequence s_any_access;
    psel && penable;
  endsequence

  property p_rst_zero;
    @(posedge pclk) disable iff (!presetn)
    !st_q.up |-> unit_clk_en == GATE_RESET && run_gates == GATE_RESET;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("gates not zero after reset");

  property p_run_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_run && !st_q.auto_gate) |-> ##2 unit_clk_en == ($past(pwdata, 2) & GATE_MASK);
  endproperty
  a_run_write: assert property (p_run_write)
    else $error("run write did not reach clock enables");

  property p_fault_sticky;
    @(posedge pclk) disable iff (!presetn)
    unit_fault |=> st_q.fault_seen;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault not recorded");

  property p_fault_gated;
    @(posedge pclk) disable iff (!presetn)
    (unit_access[ASYNC_SERIAL_BIT] && !unit_clk_en[ASYNC_SERIAL_BIT]) |-> unit_fault;
  endproperty
  a_fault_gated: assert property (p_fault_gated)
    else $error("unclocked access gave no fault");

  property p_auto_off;
    @(posedge pclk) disable iff (!presetn)
    (st_q.up && !st_q.auto_gate) |=> unit_clk_en == ($past(run_gates) & GATE_MASK);
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("run gates not used with auto gating off");

  property p_sleep_sel;
    @(posedge pclk) disable iff (!presetn)
    (st_q.auto_gate && st_q.mode == LPCG_SLEEP) |=> unit_clk_en == $past(sleep_gates);
  endproperty
  a_sleep_sel: assert property (p_sleep_sel)
    else $error("sleep gates not used in sleep");

  property p_deep_sel;
    @(posedge pclk) disable iff (!presetn)
    (st_q.auto_gate && st_q.mode == LPCG_DEEP) |=> unit_clk_en == $past(deep_gates);
  endproperty
  a_deep_sel: assert property (p_deep_sel)
    else $error("deep-sleep gates not used in deep sleep");

  property p_deep_read;
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(DEEP_GATES_OFS) ##1 s_rd_access |-> prdata == deep_gates && !pslverr;
  endproperty
  a_deep_read: assert property (p_deep_read)
    else $error("deep-sleep gate read mismatch");

  property p_sleep_read;
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(SLEEP_GATES_OFS) ##1 s_rd_access |-> prdata == sleep_gates && !pslverr;
  endproperty
  a_sleep_read: assert property (p_sleep_read)
    else $error("sleep gate read mismatch");

  property p_separate;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_sleep) |=> $stable(run_gates) && $stable(deep_gates);
  endproperty
  a_separate: assert property (p_separate)
    else $error("sleep write disturbed another gate register");

  // Deep request moves the mode to deep sleep next cycle
  property p_deep_wins;
    @(posedge pclk) disable iff (!presetn)
    deep_req |=> st_q.mode == LPCG_DEEP;
  endproperty
  a_deep_wins: assert property (p_deep_wins)
    else $error("deep request did not enter deep sleep");

  // Config write stores the auto gating select
  property p_cfg_store;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_cfg) |=> st_q.auto_gate == $past(pwdata[AUTO_GATE_BIT]);
  endproperty
  a_cfg_store: assert property (p_cfg_store)
    else $error("auto gating select not stored");

  // Unmapped address answers zero with an error
  property p_bad_addr;
    @(posedge pclk) disable iff (!presetn)
    s_bad_setup ##1 s_any_access |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("unmapped access not refused");

  // Writing one clears the fault when no new fault arrives
  property p_fault_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_stat && pwdata[FAULT_BIT] && !unit_fault) |=> !st_q.fault_seen;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault flag did not clear");

endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the peripheral clock gate block.
// Assumes the design checks its own assertions; APB wait states are honoured.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lpcg_pkg::*;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sleep_req, deep_req, unit_fault, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, unit_access, unit_clk_en, rdat;
  int n_errors = 0; // Mismatch count
  int num_checks = 0; // Comparison count
  int bits[9] = '{0, 4, 12, 16, 17, 18, 24, 25, 26}; // Gate field positions

  lpcg_top lpcg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .deep_req(deep_req),
    .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault));

  // ------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Cuts a hang short well past the expected run length
  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  // Prints counts and verdict, then ends the run
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Word compare
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare data and error flag
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, 32'h0000_0000);
    chk32(rdat, exp);
    chk1(rerr, err);
  endtask
  // Lets register and enable updates land, then leaves the edge
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sleep_req = 1'b0;
    deep_req = 1'b0;
    unit_access = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of all gate registers and enables
    rd(RUN_GATES_OFS, 32'h0000_0000, 1'b0);
    rd(SLEEP_GATES_OFS, 32'h0000_0000, 1'b0);
    rd(DEEP_GATES_OFS, 32'h0000_0000, 1'b0);
    rd(RUN_CFG_OFS, 32'h0000_0000, 1'b0);
    chk32(unit_clk_en, 32'h0000_0000);
    // Unmapped place: zero data and error, write ignored
    xfer(1'b1, 12'h200, 32'hFFFF_FFFF);
    chk1(rerr, 1'b1);
    rd(12'h200, 32'h0000_0000, 1'b1);
    // Reserved bits stay zero in every gate register
    xfer(1'b1, RUN_GATES_OFS, 32'hFFFF_FFFF);
    xfer(1'b1, SLEEP_GATES_OFS, 32'hFFFF_FFFF);
    xfer(1'b1, DEEP_GATES_OFS, 32'hFFFF_FFFF);
    rd(RUN_GATES_OFS, GATE_MASK, 1'b0);
    rd(SLEEP_GATES_OFS, GATE_MASK, 1'b0);
    rd(DEEP_GATES_OFS, GATE_MASK, 1'b0);
    // Distinct contents prove three separate registers
    xfer(1'b1, SLEEP_GATES_OFS, 32'h0007_0000);
    xfer(1'b1, DEEP_GATES_OFS, 32'h0000_1011);
    rd(RUN_GATES_OFS, GATE_MASK, 1'b0);
    rd(SLEEP_GATES_OFS, 32'h0007_0000, 1'b0);
    rd(DEEP_GATES_OFS, 32'h0000_1011, 1'b0);
    // Each gate bit alone enables its unit; others fault on access
    foreach (bits[i]) begin
      xfer(1'b1, RUN_GATES_OFS, 32'h1 << bits[i]);
      settle();
      chk32(unit_clk_en, 32'h1 << bits[i]);
      @(posedge pclk);
      unit_access <= 32'h1 << bits[i];
      #1;
      chk1(unit_fault, 1'b0);
      @(posedge pclk);
      unit_access <= GATE_MASK ^ (32'h1 << bits[i]);
      #1;
      chk1(unit_fault, 1'b1);
      @(posedge pclk);
      unit_access <= 32'h0000_0000;
    end
    // Sticky fault flag, cleared by writing one
    rd(STATUS_OFS, 32'h0000_0100, 1'b0);
    xfer(1'b1, STATUS_OFS, 32'h0000_0100);
    rd(STATUS_OFS, 32'h0000_0000, 1'b0);
    // Auto gating off: run register rules in sleep
    xfer(1'b1, RUN_GATES_OFS, GATE_MASK);
    @(posedge pclk);
    sleep_req <= 1'b1;
    settle();
    chk32(unit_clk_en, GATE_MASK);
    rd(STATUS_OFS, 32'h0000_0001, 1'b0);
    // Auto gating on: sleep then deep register rules
    xfer(1'b1, RUN_CFG_OFS, 32'h0000_0001);
    settle();
    chk32(unit_clk_en, 32'h0007_0000);
    @(posedge pclk);
    deep_req <= 1'b1;
    settle();
    chk32(unit_clk_en, 32'h0000_1011);
    rd(EFF_GATES_OFS, 32'h0000_1011, 1'b0);
    rd(STATUS_OFS, 32'h0000_0002, 1'b0);
    @(posedge pclk);
    sleep_req <= 1'b0;
    deep_req <= 1'b0;
    settle();
    chk32(unit_clk_en, GATE_MASK);
    // Reset in mid-run clears every gate again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk32(unit_clk_en, 32'h0000_0000);
    rd(RUN_GATES_OFS, 32'h0000_0000, 1'b0);
    rd(RUN_CFG_OFS, 32'h0000_0000, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
